// ### dv/host_apb_model.sv
// Host-side APB master model that issues single register accesses.
`timescale 1ns/1ps
module host_apb_model (
  // Clock
  input wire logic pclk,
  // Request towards the slave
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [8:0] paddr,
  output logic [31:0] pwdata,
  // Answer from the slave
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ---------------------------------------------------------------
  // Idle bus at time zero
  // ---------------------------------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 9'h000;
    pwdata = 32'h0;
  end

  // One transfer; entered just after a rising edge. The request is held
  // until pready is seen high, and the wait is bounded so a dead slave
  // cannot hang the run.
  task automatic xfer(input logic wr, input logic [8:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e,
      output bit ok);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    ok = (pready === 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // A spare edge keeps the next request out of this time step.
    @(posedge pclk);
  endtask
endmodule

// ### dv/protocol_status_host_interface_tb.sv
// Self-checking testbench for the protocol status register bank.
`timescale 1ns/1ps
module protocol_status_host_interface_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [8:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic e, corr_strobe, sync_list_we, sync_list_commit;
  logic startup_pair_strobe;
  pstat_pkg::opctl_status_s opctl;
  pstat_pkg::cycle_timing_s timing;
  pstat_pkg::correction_s corr;
  pstat_pkg::event_s events;
  logic [4:0] missed, startup_pair_count;
  logic [1:0] sync_list_sel;
  logic [3:0] sync_list_idx, sync_list_count;
  logic [10:0] sync_list_id;
  int failures = 0;
  int check_count = 0;

  // ---------------------------------------------------------------
  // Host model and device
  // ---------------------------------------------------------------
  host_apb_model host_u (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  protocol_status_host_interface #(.has_gateway_sink(1'b1)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .opctl_in(opctl),
    .timing_in(timing), .corr_in(corr), .corr_strobe(corr_strobe),
    .events_in(events), .missed_correction_pair_count(missed),
    .sync_list_we(sync_list_we), .sync_list_sel(sync_list_sel),
    .sync_list_idx(sync_list_idx), .sync_list_id(sync_list_id),
    .sync_list_commit(sync_list_commit),
    .sync_list_count(sync_list_count),
    .startup_pair_strobe(startup_pair_strobe),
    .startup_pair_count(startup_pair_count));

  // Free-running 250 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  // Counts every comparison and reports a mismatch at once.
  task automatic check(input string nm, input logic [31:0] s,
      input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // A bus access that never completes ends the run as a mismatch.
  task automatic acc(input logic w, input logic [8:0] a,
      input logic [31:0] d);
    bit ok;
    host_u.xfer(w, a, d, r, e, ok);
    if (!ok) begin
      failures++;
      complete_run();
    end
  endtask

  task automatic rd(input string nm, input logic [8:0] a,
      input logic [31:0] x);
    acc(1'b0, a, 32'h0);
    check(nm, r, x);
  endtask

  // One-cycle pulse on the engine's event lines.
  task automatic pulse(input logic [7:0] v);
    events <= v;
    @(posedge pclk);
    events <= 8'h00;
    @(posedge pclk);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    opctl = '0;
    timing = '0;
    corr = '0;
    events = '0;
    missed = 5'h00;
    corr_strobe = 1'b0;
    sync_list_we = 1'b0;
    sync_list_commit = 1'b0;
    sync_list_sel = 2'h0;
    sync_list_idx = 4'h0;
    sync_list_id = 11'h000;
    sync_list_count = 4'h0;
    startup_pair_strobe = 1'b0;
    startup_pair_count = 5'h00;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("ind_rst", pstat_pkg::indicator_off, 32'h0);
    $display("test reset done");
    // Status fields are laid out in the field order of the carrier structs.
    opctl <= {4'h5, 1'b1, 1'b0, 1'b1, 1'b1, 2'h2, 2'h1, 5'h13, 3'h6,
      4'h9, 1'b1, 5'h0b};
    timing <= {14'h2abc, 6'h2d, 11'h5a5, 11'h3c3};
    missed <= 5'h17;
    @(posedge pclk);
    rd("opctl", pstat_pkg::opctl_status_off, {11'h0, 4'h5, 1'b1, 1'b0,
      1'b1, 1'b1, 2'h2, 2'h1, 5'h13, 3'h6, 1'b1});
    rd("startup", pstat_pkg::startup_status_off, {18'h0, 4'h9, 5'h00,
      5'h0b});
    acc(1'b1, pstat_pkg::cycle_timing_off, 32'hffffffff);
    rd("timing", pstat_pkg::cycle_timing_off, {7'h0, 5'h17, 6'h2d,
      14'h2abc});
    rd("slots", pstat_pkg::slot_counter_off, {5'h0, 11'h3c3, 5'h0,
      11'h5a5});
    rd("unmapped", 9'h01c, 32'h0);
    check("slverr", {31'h0, e}, 32'h1);
    $display("test status done");
    // Snapshot source follows the gateway flag; inputs move afterwards.
    for (int g = 0; g < 2; g++) begin
      opctl.gateway_sync_flag <= g[0];
      corr <= {16'h1234, 16'h5678, 16'h9abc, 16'hdef0};
      @(posedge pclk);
      corr_strobe <= 1'b1;
      @(posedge pclk);
      corr_strobe <= 1'b0;
      corr <= '0;
      rd("corr", pstat_pkg::correction_off, g ? 32'hdef05678 :
        32'h9abc1234);
    end
    startup_pair_count <= 5'h1d;
    startup_pair_strobe <= 1'b1;
    @(posedge pclk);
    startup_pair_strobe <= 1'b0;
    startup_pair_count <= 5'h00;
    rd("pairs", pstat_pkg::startup_status_off, {18'h0, 4'h9, 5'h1d,
      5'h0b});
    $display("test snapshots done");
    // Each event sets its own bit only; a one written clears it.
    for (int i = 0; i < 8; i++) begin
      pulse(8'h80 >> i);
      rd("ind_set", pstat_pkg::indicator_off,
        32'h1 << i);
      acc(1'b1, pstat_pkg::indicator_off, 32'h1 << i);
      rd("ind_clr", pstat_pkg::indicator_off, 32'h0);
    end
    // An event on the clearing write's access edge must survive it.
    pulse(8'h80);
    fork
      acc(1'b1, pstat_pkg::indicator_off, 32'h1);
      begin
        @(posedge pclk);
        events <= 8'h80;
        @(posedge pclk);
        events <= 8'h00;
      end
    join
    rd("set_wins", pstat_pkg::indicator_off, 32'h1);
    // Entering config or default config clears every indicator.
    for (int k = 0; k < 2; k++) begin
      pulse(8'hff);
      opctl.opctl_state <= k ? pstat_pkg::opctl_config :
        pstat_pkg::opctl_default_config;
      repeat (2) @(posedge pclk);
      rd("cfg_clr", pstat_pkg::indicator_off, 32'h0);
      opctl.opctl_state <= 4'h5;
      @(posedge pclk);
    end
    $display("test indicators done");
    // First entry of the first list and last entry of the last list,
    // then counts for all four lists.
    for (int j = 0; j < 2; j++) begin
      sync_list_we <= 1'b1;
      sync_list_sel <= j ? 2'h3 : 2'h0;
      sync_list_idx <= j ? 4'he : 4'h0;
      sync_list_id <= j ? 11'h7ee : 11'h4a5;
      @(posedge pclk);
      sync_list_we <= 1'b0;
      @(posedge pclk);
    end
    for (int s = 0; s < 4; s++) begin
      sync_list_commit <= 1'b1;
      sync_list_sel <= s[1:0];
      sync_list_count <= 4'(s * 4 + 3);
      @(posedge pclk);
      sync_list_commit <= 1'b0;
      @(posedge pclk);
    end
    rd("list0", pstat_pkg::sync_list_base_off, 32'h4a5);
    rd("list59", 9'h12c, 32'h7ee);
    rd("list_end", 9'h130, 32'h0);
    check("list_slverr", {31'h0, e}, 32'h1);
    rd("counts", pstat_pkg::sync_count_off, 32'hfb73);
    $display("test sync lists done");
    complete_run();
  end
endmodule

// ### shared/pstat_pkg.sv
// Package of register map, field layout and carrier types for protocol status.
package pstat_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one aligned word each except the 60-word sync list block at the list base)
  // ----------------------------------------------------------------
  localparam logic [8:0] opctl_status_off = 9'h000;
  localparam logic [8:0] startup_status_off = 9'h004;
  localparam logic [8:0] indicator_off = 9'h008;
  localparam logic [8:0] cycle_timing_off = 9'h00c;
  localparam logic [8:0] slot_counter_off = 9'h010;
  localparam logic [8:0] correction_off = 9'h014;
  localparam logic [8:0] sync_count_off = 9'h018;
  localparam logic [8:0] sync_list_base_off = 9'h040;

  // ----------------------------------------------------------------
  // Indicator bit positions in the indicator register
  // ----------------------------------------------------------------
  localparam int coldstart_abort_bit = 0;
  localparam int wakeup_rx_a_bit = 1;
  localparam int wakeup_rx_b_bit = 2;
  localparam int sync_overflow_bit = 3;
  localparam int latest_tx_a_bit = 4;
  localparam int latest_tx_b_bit = 5;
  localparam int boundary_a_bit = 6;
  localparam int boundary_b_bit = 7;
  localparam int num_indicators = 8;
  localparam logic [7:0] indicator_reset = 8'h00;

  // ----------------------------------------------------------------
  // List geometry and protocol state encodings
  // ----------------------------------------------------------------
  localparam int list_depth = 15;
  localparam int num_lists = 4;
  localparam logic [3:0] opctl_default_config = 4'h0;
  localparam logic [3:0] opctl_config = 4'h1;

  // ----------------------------------------------------------------
  // Carriers from the protocol engine
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] opctl_state;
    logic opctl_freeze_flag;
    logic host_ready_request_flag;
    logic host_halt_request_flag;
    logic coldstart_noise_flag;
    logic [1:0] slot_transmission_mode;
    logic [1:0] error_severity_mode;
    logic [4:0] passive_to_active_pair_count;
    logic [2:0] wakeup_outcome;
    logic [3:0] startup_phase;
    logic gateway_sync_flag;
    logic [4:0] coldstart_tries_left;
  } opctl_status_s;

  typedef struct packed {
    logic [13:0] current_macrotick;
    logic [5:0] cycle_number;
    logic [10:0] slot_number_a;
    logic [10:0] slot_number_b;
  } cycle_timing_s;

  typedef struct packed {
    logic [15:0] rate_internal;
    logic [15:0] rate_gateway;
    logic [15:0] offset_internal;
    logic [15:0] offset_gateway;
  } correction_s;

  typedef struct packed {
    logic coldstart_abort;
    logic wakeup_rx_a;
    logic wakeup_rx_b;
    logic sync_overflow;
    logic latest_tx_a;
    logic latest_tx_b;
    logic boundary_a;
    logic boundary_b;
  } event_s;

endpackage

// ### src/protocol_status_host_interface.sv
// Host-visible protocol status register bank with APB slave.
`timescale 1ns/1ps
//
// Functional notes
// - Indicators are two-valued, set by events, host-cleared.
// - Indicators clear entering default-config or config.
// - Operation control status fields readable by host.
// - Passive-to-active pair count is readable.
// - Gateway sync flag false when gateway absent.
// - Remaining coldstart attempts readable.
// - Coldstart abort indicator sticky until host clear.
// - Wakeup received indicator per channel A, B.
// - Macrotick, cycle, per-channel slot counters readable.
// - Rate snapshot source selected by gateway sync.
// - Offset snapshot source selected by gateway sync.
// - Sync frame overflow indicator sticky.
// - Latest transmit start violation per channel.
// - Slot boundary transmit violation per channel.
// - Four sync ID lists with valid counts.
// - Sync lists update within the allowed window.
// - Missed correction pair count readable.
// - Startup pair snapshot over both channels.
// - External-sync coldstart node startup pair timing.
// - Other nodes startup pair update timing.

module protocol_status_host_interface #(
  parameter bit has_gateway_sink = 1'b1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [8:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Protocol engine status
  input wire pstat_pkg::opctl_status_s opctl_in,
  input wire pstat_pkg::cycle_timing_s timing_in,
  input wire pstat_pkg::correction_s corr_in,
  input wire logic corr_strobe,
  input wire pstat_pkg::event_s events_in,
  input wire logic [4:0] missed_correction_pair_count,
  // Sync list write port and startup pair snapshot from the clock sync process
  input wire logic sync_list_we,
  input wire logic [1:0] sync_list_sel,
  input wire logic [3:0] sync_list_idx,
  input wire logic [10:0] sync_list_id,
  input wire logic sync_list_commit,
  input wire logic [3:0] sync_list_count,
  input wire logic startup_pair_strobe,
  input wire logic [4:0] startup_pair_count
);

  // ----------------------------------------------------------------
  // Internal state
  // ----------------------------------------------------------------
  logic [pstat_pkg::num_indicators-1:0] indicators;
  logic [pstat_pkg::num_indicators-1:0] event_vec;
  logic [3:0] prev_state;
  logic config_entry;
  logic gw_sync;
  logic [15:0] rate_correction_snapshot;
  logic [15:0] offset_correction_snapshot;
  logic [10:0] sync_ids [pstat_pkg::num_lists*pstat_pkg::list_depth];
  logic [3:0] sync_counts [pstat_pkg::num_lists];
  logic [4:0] startup_pairs;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] next_rdata;

  // Absent gateway sink behaves as if the sync flag were false.
  assign gw_sync = has_gateway_sink & opctl_in.gateway_sync_flag;

  // Event vector in indicator bit order.
  assign event_vec = {events_in.boundary_b, events_in.boundary_a,
                      events_in.latest_tx_b, events_in.latest_tx_a,
                      events_in.sync_overflow, events_in.wakeup_rx_b,
                      events_in.wakeup_rx_a, events_in.coldstart_abort};

  // ----------------------------------------------------------------
  // Configuration-state entry detection
  // ----------------------------------------------------------------
  // Tracks the previous state so each entry is seen once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_state <= pstat_pkg::opctl_default_config;
    end else begin
      prev_state <= opctl_in.opctl_state;
    end
  end

  assign config_entry = (opctl_in.opctl_state != prev_state) &&
    ((opctl_in.opctl_state == pstat_pkg::opctl_default_config) ||
     (opctl_in.opctl_state == pstat_pkg::opctl_config));

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~pwrite;
  assign pready = 1'b1;

  // ----------------------------------------------------------------
  // Sticky indicators
  // ----------------------------------------------------------------
  // One loop per bit; the event term is first so a set beats the clear.
  genvar g;
  generate
    for (g = 0; g < pstat_pkg::num_indicators; g++) begin : g_ind
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          indicators[g] <= pstat_pkg::indicator_reset[g];
        end else if (event_vec[g]) begin
          indicators[g] <= 1'b1;
        end else if (config_entry) begin
          indicators[g] <= 1'b0;
        end else if (wr_en && paddr == pstat_pkg::indicator_off &&
                     pwdata[g]) begin
          indicators[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Correction snapshots
  // ----------------------------------------------------------------
  // Internal values are taken unclamped; the gateway values already hold
  // the source's limits and external terms.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_correction_snapshot <= 16'h0000;
      offset_correction_snapshot <= 16'h0000;
    end else if (corr_strobe) begin
      rate_correction_snapshot <= gw_sync ? corr_in.rate_gateway
                                          : corr_in.rate_internal;
      offset_correction_snapshot <= gw_sync ? corr_in.offset_gateway
                                            : corr_in.offset_internal;
    end
  end

  // ----------------------------------------------------------------
  // Sync ID lists
  // ----------------------------------------------------------------
  // The engine writes entries and commits counts within the window that
  // opens at idle time; the block stores them in that same cycle.
  always_ff @(posedge pclk) begin
    if (sync_list_we && sync_list_idx < 4'(pstat_pkg::list_depth)) begin
      sync_ids[sync_list_sel * pstat_pkg::list_depth + sync_list_idx]
        <= sync_list_id;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < pstat_pkg::num_lists; i++) begin
        sync_counts[i] <= 4'h0;
      end
    end else if (sync_list_commit) begin
      sync_counts[sync_list_sel] <= sync_list_count;
    end
  end

  // ----------------------------------------------------------------
  // Startup pair snapshot
  // ----------------------------------------------------------------
  // The strobe timing follows the node role; the block captures at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      startup_pairs <= 5'h00;
    end else if (startup_pair_strobe) begin
      startup_pairs <= startup_pair_count;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    addr_ok = 1'b1;
    if (paddr == pstat_pkg::opctl_status_off) begin
      next_rdata = {11'h000, opctl_in.opctl_state, opctl_in.opctl_freeze_flag,
        opctl_in.host_ready_request_flag, opctl_in.host_halt_request_flag,
        opctl_in.coldstart_noise_flag, opctl_in.slot_transmission_mode,
        opctl_in.error_severity_mode, opctl_in.passive_to_active_pair_count,
        opctl_in.wakeup_outcome, gw_sync};
    end else if (paddr == pstat_pkg::startup_status_off) begin
      next_rdata = {18'h00000, opctl_in.startup_phase,
        startup_pairs, opctl_in.coldstart_tries_left};
    end else if (paddr == pstat_pkg::indicator_off) begin
      next_rdata = {24'h000000, indicators};
    end else if (paddr == pstat_pkg::cycle_timing_off) begin
      next_rdata = {7'h00, missed_correction_pair_count,
        timing_in.cycle_number, timing_in.current_macrotick};
    end else if (paddr == pstat_pkg::slot_counter_off) begin
      next_rdata = {5'h00, timing_in.slot_number_b, 5'h00,
        timing_in.slot_number_a};
    end else if (paddr == pstat_pkg::correction_off) begin
      next_rdata = {offset_correction_snapshot, rate_correction_snapshot};
    end else if (paddr == pstat_pkg::sync_count_off) begin
      next_rdata = {16'h0000, sync_counts[3], sync_counts[2],
        sync_counts[1], sync_counts[0]};
    end else if (paddr >= pstat_pkg::sync_list_base_off &&
                 paddr < 9'(pstat_pkg::sync_list_base_off +
                 4 * pstat_pkg::num_lists * pstat_pkg::list_depth)) begin
      next_rdata = {21'h000000,
        sync_ids[6'((paddr - pstat_pkg::sync_list_base_off) >> 2)]};
    end else begin
      addr_ok = 1'b0;
    end
  end

  assign pslverr = psel & penable & ~addr_ok;

  // ----------------------------------------------------------------
  // Read data register
  // ----------------------------------------------------------------
  // Loaded on the setup edge, so the word stands through the access
  // phase and cannot race a register that updates on the access edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en && !penable) begin
      prdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_event_sets;
    @(posedge pclk) disable iff (!presetn)
      events_in.coldstart_abort |=> indicators[pstat_pkg::coldstart_abort_bit];
  endproperty
  a_event_sets: assert property (p_event_sets)
    else $error("Coldstart abort indicator not set.");

  property p_sticky;
    @(posedge pclk) disable iff (!presetn)
      indicators[pstat_pkg::wakeup_rx_a_bit] && !config_entry &&
      !(wr_en && paddr == pstat_pkg::indicator_off)
      |=> indicators[pstat_pkg::wakeup_rx_a_bit];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("Wakeup indicator dropped without a clear.");

  property p_cfg_clear;
    @(posedge pclk) disable iff (!presetn)
      config_entry && !events_in.sync_overflow
      |=> !indicators[pstat_pkg::sync_overflow_bit];
  endproperty
  a_cfg_clear: assert property (p_cfg_clear)
    else $error("Indicator survived a configuration entry.");

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
      wr_en && paddr == pstat_pkg::indicator_off && events_in.latest_tx_b
      |=> indicators[pstat_pkg::latest_tx_b_bit];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("Host clear beat a simultaneous event.");

  property p_rate_src;
    @(posedge pclk) disable iff (!presetn)
      corr_strobe && !gw_sync
      |=> rate_correction_snapshot == $past(corr_in.rate_internal);
  endproperty
  a_rate_src: assert property (p_rate_src)
    else $error("Rate snapshot from wrong source.");

  property p_offset_src;
    @(posedge pclk) disable iff (!presetn)
      corr_strobe && gw_sync
      |=> offset_correction_snapshot == $past(corr_in.offset_gateway);
  endproperty
  a_offset_src: assert property (p_offset_src)
    else $error("Offset snapshot from wrong source.");

  property p_no_gateway;
    @(posedge pclk) disable iff (!presetn)
      !has_gateway_sink |-> !gw_sync;
  endproperty
  a_no_gateway: assert property (p_no_gateway)
    else $error("Gateway sync seen without a sink.");

  property p_pairs;
    @(posedge pclk) disable iff (!presetn)
      startup_pair_strobe |=> startup_pairs == $past(startup_pair_count);
  endproperty
  a_pairs: assert property (p_pairs)
    else $error("Startup pair snapshot not captured.");

  property p_count_commit;
    @(posedge pclk) disable iff (!presetn)
      sync_list_commit |=>
        sync_counts[$past(sync_list_sel)] == $past(sync_list_count);
  endproperty
  a_count_commit: assert property (p_count_commit)
    else $error("Sync list count not committed.");

  // Host access steps: a setup cycle, then the access cycle after it.
  sequence s_read(logic [8:0] a);
    psel && !penable && !pwrite && paddr == a ##1 psel && penable;
  endsequence

  sequence s_ind_write(int b);
    psel && !penable && pwrite && paddr == pstat_pkg::indicator_off &&
      pwdata[b] ##1 psel && penable;
  endsequence

  // The word read back is the one decoded on the setup edge.
  property p_ind_readback;
    @(posedge pclk) disable iff (!presetn)
      s_read(pstat_pkg::indicator_off) |->
        prdata == {24'h000000, $past(indicators)};
  endproperty
  a_ind_readback: assert property (p_ind_readback)
    else $error("Indicator word read back wrong.");

  property p_state_readback;
    @(posedge pclk) disable iff (!presetn)
      s_read(pstat_pkg::opctl_status_off) |->
        prdata[20:17] == $past(opctl_in.opctl_state);
  endproperty
  a_state_readback: assert property (p_state_readback)
    else $error("Operation state read back wrong.");

  property p_macrotick_readback;
    @(posedge pclk) disable iff (!presetn)
      s_read(pstat_pkg::cycle_timing_off) |->
        prdata[13:0] == $past(timing_in.current_macrotick);
  endproperty
  a_macrotick_readback: assert property (p_macrotick_readback)
    else $error("Macrotick read back wrong.");

  property p_pairs_readback;
    @(posedge pclk) disable iff (!presetn)
      s_read(pstat_pkg::startup_status_off) |->
        prdata[9:5] == $past(startup_pairs);
  endproperty
  a_pairs_readback: assert property (p_pairs_readback)
    else $error("Startup pair count read back wrong.");

  property p_count_readback;
    @(posedge pclk) disable iff (!presetn)
      s_read(pstat_pkg::sync_count_off) |->
        prdata[3:0] == $past(sync_counts[0]);
  endproperty
  a_count_readback: assert property (p_count_readback)
    else $error("Sync list count read back wrong.");

  // Every indicator bit gets the same guards: an event always lands,
  // and a host one clears the bit unless an event arrives with it.
  generate
    for (g = 0; g < pstat_pkg::num_indicators; g++) begin : g_ind_chk
      property p_bit_set;
        @(posedge pclk) disable iff (!presetn)
          event_vec[g] |=> indicators[g];
      endproperty
      a_bit_set: assert property (p_bit_set)
        else $error("Indicator event was lost.");

      property p_bit_host_clear;
        @(posedge pclk) disable iff (!presetn)
          s_ind_write(g) ##0 !event_vec[g] |=> !indicators[g];
      endproperty
      a_bit_host_clear: assert property (p_bit_host_clear)
        else $error("Host clear did not take effect.");

      property p_bit_cfg_clear;
        @(posedge pclk) disable iff (!presetn)
          config_entry && !event_vec[g] |=> !indicators[g];
      endproperty
      a_bit_cfg_clear: assert property (p_bit_cfg_clear)
        else $error("Config entry left an indicator set.");
    end
  endgenerate

endmodule
